// *** evs_bus_partner.sv ***
// Memory and interrupting device model on the system bus
`timescale 1ns/10ps
`default_nettype none
module evs_bus_partner (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        bus_req_in,
	input  wire logic [31:0] bus_addr_in,
	input  wire logic [2:0]  bus_fc_in,
	input  wire logic [2:0]  dly_in,
	input  wire logic [1:0]  iack_mode_in,
	input  wire logic [7:0]  iack_vec_in,
	output var  logic        ack_out,
	output var  logic        err_out,
	output var  logic        autovec_out,
	output var  logic [31:0] rdata_out
);
	logic [2:0] cnt_ff;
	wire        resp = ack_out | err_out | autovec_out;
	wire        iack = bus_fc_in == 3'h7;
	// Answer after dly_in waits; idle data toggles
	always @(posedge clk_in) begin
		ack_out <= 1'b0;
		err_out <= 1'b0;
		autovec_out <= 1'b0;
		rdata_out <= rst_n_in ? ~rdata_out : 32'h5a5a_5a5a;
		if (!rst_n_in || !bus_req_in || resp) begin
			cnt_ff <= 3'h0;
		end else if (cnt_ff < dly_in) begin
			cnt_ff <= cnt_ff + 3'h1;
		end else begin
			ack_out <= !iack || iack_mode_in == 2'h0;
			autovec_out <= iack && iack_mode_in == 2'h1;
			err_out <= iack && iack_mode_in == 2'h2;
			rdata_out <= iack ? {24'h0, iack_vec_in} : {~bus_addr_in[15:0], bus_addr_in[15:0]};
		end
	end
endmodule // evs_bus_partner
`default_nettype wire

// *** evs_exception_vector_sequencer.v ***
// Exception entry sequencer: vector table, acknowledge, frame push, handler load
`timescale 1ns/10ps
`default_nettype none
`include "evs_regs.vh"
module evs_exception_vector_sequencer #(
	parameter AW = 32
) (
	input  wire          clk_in,
	input  wire          rst_n_in,
	// Register port
	input  wire [3:0]    reg_addr_in,
	input  wire [31:0]   reg_wdata_in,
	input  wire          reg_wr_in,
	input  wire          reg_rd_in,
	output reg  [31:0]   reg_rdata_out,
	// Exception causes from the core
	input  wire          ex_trap_in,
	input  wire [3:0]    ex_trap_num_in,
	input  wire          ex_cond_trap_in,
	input  wire          ex_bounds_in,
	input  wire          ex_divzero_in,
	input  wire          ex_format_in,
	input  wire          ex_priv_in,
	input  wire          ex_odd_addr_in,
	input  wire          ex_bus_err_in,
	input  wire          ex_hw_breakpoint_op_in,
	input  wire          ex_insn_done_in,
	input  wire          ex_flow_change_in,
	input  wire          ex_trace_flow_only_in,
	input  wire          ex_opcode_valid_in,
	input  wire [15:0]   ex_opcode_in,
	input  wire          ex_return_in,
	input  wire [15:0]   ex_return_sr_in,
	input  wire [31:0]   ex_return_pc_in,
	input  wire [31:0]   core_pc_in,
	// Interrupt request
	input  wire [2:0]    irq_level_in,
	// System bus
	// Function codes: 5 supervisor data, 6 supervisor program, 7 CPU space
	output reg           bus_req_out,
	output reg           bus_wr_out,
	output reg  [AW-1:0] bus_addr_out,
	output reg  [2:0]    bus_fc_out,
	output reg  [31:0]   bus_wdata_out,
	input  wire          bus_ack_in,
	input  wire          bus_err_in,
	input  wire          bus_autovec_in,
	input  wire [31:0]   bus_rdata_in,
	// Core control
	output reg           core_hold_out,
	output reg           pc_load_out,
	output reg  [31:0]   pc_value_out,
	output reg  [15:0]   status_word_out
);

	// ======================================================
	// States
	// Reset fetches come first; ST_RUN is the only state in which the
	// core runs, every other state holds it
	localparam ST_RESET_SP = 4'h0;
	localparam ST_RESET_PC = 4'h1;
	localparam ST_RUN      = 4'h2;
	localparam ST_IACK     = 4'h3;
	localparam ST_PUSH_PC  = 4'h4;
	localparam ST_PUSH_SR  = 4'h5;
	localparam ST_FETCH    = 4'h6;
	localparam ST_LOAD     = 4'h7;

	// Vector address: base plus four times the vector number
	// Shared by the reset fetches, with a zero base, and the handler fetch
	function [31:0] vec_addr;
		input [31:0] base;
		input [7:0]  num;
		begin
			vec_addr = base + {22'h0, num, 2'b00};
		end
	endfunction

	// Sequencer state and saved context
	reg [3:0]  state_ff,   nxt_state;
	reg [31:0] vbase_ff;
	reg [15:0] sr_ff,      nxt_sr;
	reg [15:0] sr_copy_ff, nxt_sr_copy;
	reg [31:0] pc_copy_ff, nxt_pc_copy;
	reg [31:0] ssp_ff,     nxt_ssp;
	reg [7:0]  vec_ff,     nxt_vec;
	reg [2:0]  ilvl_ff,    nxt_ilvl;
	reg        is_int_ff,  nxt_is_int;
	reg        trace_pend_ff;

	// ======================================================
	// Internal cause decode, priority highest first
	// One cause is served per entry, the highest one present
	// Numbers 13, 16-23 and 48-63 never come out of this decode
	reg        cause_hit;
	reg [7:0]  cause_vec;
	wire       trace_on = sr_ff[`EVS_SR_TH] | sr_ff[`EVS_SR_TL];
	// Unimplemented opcode lines get their own vectors
	wire       line_a   = ex_opcode_valid_in & (ex_opcode_in[15:12] == 4'ha);
	wire       line_f   = ex_opcode_valid_in & (ex_opcode_in[15:12] == 4'hf);
	wire       sw_breakpoint_op  = ex_opcode_valid_in & (ex_opcode_in[15:3] == `EVS_OP_SWBKPT);
	// Level 7 cannot be masked; lower levels must beat the mask
	wire       irq_take = (irq_level_in == 3'h7) | (irq_level_in > sr_ff[`EVS_SR_IPM_HI:`EVS_SR_IPM_LO]);
	always @* begin
		// Assume a hit; the final else clears it
		cause_hit = 1'b1;
		cause_vec = `EVS_VEC_BUSERR;
		if (ex_bus_err_in)
			cause_vec = `EVS_VEC_BUSERR;
		else if (ex_odd_addr_in)
			cause_vec = `EVS_VEC_ADDRERR;
		else if (ex_hw_breakpoint_op_in)
			cause_vec = `EVS_VEC_HWBKPT;
		// Software breakpoints take the illegal opcode vector
		else if (sw_breakpoint_op)
			cause_vec = `EVS_VEC_ILLEGAL;
		else if (line_a)
			cause_vec = `EVS_VEC_LINE_A;
		else if (line_f)
			cause_vec = `EVS_VEC_LINE_F;
		else if (ex_priv_in)
			cause_vec = `EVS_VEC_PRIV;
		else if (ex_format_in)
			cause_vec = `EVS_VEC_FORMAT;
		else if (ex_trap_in)
			cause_vec = `EVS_VEC_TRAP0 + {4'h0, ex_trap_num_in};
		else if (ex_cond_trap_in)
			cause_vec = `EVS_VEC_CONDITIONAL_TRAP_OP;
		else if (ex_bounds_in)
			cause_vec = `EVS_VEC_BOUNDS;
		else if (ex_divzero_in)
			cause_vec = `EVS_VEC_ZERODIV;
		else if (trace_pend_ff)
			cause_vec = `EVS_VEC_TRACE;
		// Opcode that the core cannot execute
		else if (ex_opcode_valid_in & ~ex_insn_done_in)
			cause_vec = `EVS_VEC_ILLEGAL;
		else
			cause_hit = 1'b0;
	end

	// ======================================================
	// Trace pending after each completed instruction
	// A new completion wins over the clear in the same cycle
	always @(posedge clk_in) begin
		if (!rst_n_in)
			trace_pend_ff <= 1'b0;
		else if (state_ff == ST_RUN && ex_insn_done_in && trace_on &&
			(~ex_trace_flow_only_in | ex_flow_change_in))
			trace_pend_ff <= 1'b1;
		else if (state_ff == ST_RUN && cause_hit && cause_vec == `EVS_VEC_TRACE)
			trace_pend_ff <= 1'b0;
	end

	// ======================================================
	// Sequencer next state
	// Entry order: status copy, acknowledge for interrupts, PC push,
	// status push, handler fetch, then the load cycle
	always @* begin
		nxt_state   = state_ff;
		nxt_sr      = sr_ff;
		nxt_sr_copy = sr_copy_ff;
		nxt_pc_copy = pc_copy_ff;
		nxt_ssp     = ssp_ff;
		nxt_vec     = vec_ff;
		nxt_ilvl    = ilvl_ff;
		nxt_is_int  = is_int_ff;
		case (state_ff)
			// Initial stack pointer, then initial PC
			ST_RESET_SP: begin
				if (bus_ack_in) begin
					nxt_ssp   = bus_rdata_in;
					nxt_state = ST_RESET_PC;
				end
			end
			ST_RESET_PC: begin
				if (bus_ack_in) begin
					nxt_pc_copy = bus_rdata_in;
					nxt_state   = ST_LOAD;
				end
			end
			ST_RUN: begin
				// Return: status back from the frame, six bytes popped
				if (ex_return_in && ex_insn_done_in) begin
					nxt_sr  = ex_return_sr_in;
					nxt_ssp = ssp_ff + 32'h6;
				end else if (cause_hit || (irq_level_in != 3'h0 && irq_take)) begin
					// Status copy then state change first
					nxt_sr_copy = sr_ff;
					nxt_pc_copy = core_pc_in;
					nxt_sr[`EVS_SR_S]  = 1'b1;
					nxt_sr[`EVS_SR_TH] = 1'b0;
					nxt_sr[`EVS_SR_TL] = 1'b0;
					nxt_is_int = ~cause_hit;
					nxt_vec    = cause_vec;
					if (!cause_hit) begin
						nxt_ilvl = irq_level_in;
						nxt_sr[`EVS_SR_IPM_HI:`EVS_SR_IPM_LO] = irq_level_in;
						nxt_state = ST_IACK;
					end else
						nxt_state = ST_PUSH_PC;
				end
			end
			// Device answers with a number, an autovector request or an error
			ST_IACK: begin
				if (bus_ack_in) begin
					nxt_vec   = bus_rdata_in[7:0];
					nxt_state = ST_PUSH_PC;
				end else if (bus_autovec_in) begin
					nxt_vec   = `EVS_VEC_AUTO0 + {5'h0, ilvl_ff};
					nxt_state = ST_PUSH_PC;
				end else if (bus_err_in) begin
					nxt_vec   = `EVS_VEC_SPUR;
					nxt_state = ST_PUSH_PC;
				end
			end
			// Frame: PC long word on top, status word below it
			ST_PUSH_PC: begin
				if (bus_ack_in) begin
					nxt_ssp   = ssp_ff - 32'h4;
					nxt_state = ST_PUSH_SR;
				end
			end
			// Status word goes two bytes below the PC
			ST_PUSH_SR: begin
				if (bus_ack_in) begin
					nxt_ssp   = ssp_ff - 32'h2;
					nxt_state = ST_FETCH;
				end
			end
			// Handler address read from the table
			ST_FETCH: begin
				if (bus_ack_in) begin
					nxt_pc_copy = bus_rdata_in;
					nxt_state   = ST_LOAD;
				end
			end
			// One cycle to hand the handler address to the core
			ST_LOAD: nxt_state = ST_RUN;
			default: nxt_state = ST_RUN;
		endcase
	end

	// ======================================================
	// Sequencer registers
	// Register writes land only when the sequencer leaves the register alone
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_ff   <= ST_RESET_SP;
			sr_ff      <= `EVS_SR_RESET;
			sr_copy_ff <= 16'h0000;
			pc_copy_ff <= 32'h0000_0000;
			ssp_ff     <= 32'h0000_0000;
			vec_ff     <= 8'h00;
			ilvl_ff    <= 3'h0;
			is_int_ff  <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			sr_ff      <= nxt_sr;
			sr_copy_ff <= nxt_sr_copy;
			pc_copy_ff <= nxt_pc_copy;
			ssp_ff     <= nxt_ssp;
			vec_ff     <= nxt_vec;
			ilvl_ff    <= nxt_ilvl;
			is_int_ff  <= nxt_is_int;
			// Entry must not lose its supervisor bit to a software write
			if (reg_wr_in && reg_addr_in == `EVS_ADDR_STATUS && nxt_sr == sr_ff)
				sr_ff <= reg_wdata_in[15:0];
			if (reg_wr_in && reg_addr_in == `EVS_ADDR_SSP && nxt_ssp == ssp_ff)
				ssp_ff <= reg_wdata_in;
		end
	end

	// ======================================================
	// Base register, relocatable any time
	// A rewrite takes effect on the next handler fetch
	always @(posedge clk_in) begin
		if (!rst_n_in)
			vbase_ff <= `EVS_BASE_RESET;
		else if (reg_wr_in && reg_addr_in == `EVS_ADDR_BASE)
			vbase_ff <= reg_wdata_in;
	end

	// ======================================================
	// Bus request drive, registered
	// A request stands through the answer cycle; it drops in the cycle after the answer,
	// so two bus cycles are always at least one idle cycle apart
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			bus_req_out   <= 1'b0;
			bus_wr_out    <= 1'b0;
			bus_addr_out  <= {AW{1'b0}};
			bus_fc_out    <= 3'h0;
			bus_wdata_out <= 32'h0000_0000;
		end else begin
			bus_req_out   <= 1'b0;
			bus_wr_out    <= 1'b0;
			bus_wdata_out <= 32'h0000_0000;
			if (!bus_ack_in && !bus_err_in && !bus_autovec_in) begin
				case (nxt_state)
					// Reset fetches use a fixed zero base
					ST_RESET_SP: begin
						bus_req_out  <= 1'b1;
						bus_addr_out <= vec_addr(32'h0, `EVS_VEC_RST_SP);
						bus_fc_out   <= `EVS_FC_SUP_PROG;
					end
					ST_RESET_PC: begin
						bus_req_out  <= 1'b1;
						bus_addr_out <= vec_addr(32'h0, `EVS_VEC_RST_PC);
						bus_fc_out   <= `EVS_FC_SUP_PROG;
					end
					// Acknowledge address carries the level
					ST_IACK: begin
						bus_req_out  <= 1'b1;
						bus_addr_out <= {{(AW-8){1'b1}}, `EVS_CPU_SPACE_IACK, nxt_ilvl, 1'b1};
						bus_fc_out   <= `EVS_FC_CPU;
					end
					ST_PUSH_PC: begin
						bus_req_out   <= 1'b1;
						bus_wr_out    <= 1'b1;
						bus_addr_out  <= nxt_ssp - 32'h4;
						bus_fc_out    <= `EVS_FC_SUP_DATA;
						bus_wdata_out <= nxt_pc_copy;
					end
					ST_PUSH_SR: begin
						bus_req_out   <= 1'b1;
						bus_wr_out    <= 1'b1;
						bus_addr_out  <= nxt_ssp - 32'h2;
						bus_fc_out    <= `EVS_FC_SUP_DATA;
						bus_wdata_out <= {16'h0000, nxt_sr_copy};
					end
					ST_FETCH: begin
						bus_req_out  <= 1'b1;
						bus_addr_out <= vec_addr(vbase_ff, nxt_vec);
						bus_fc_out   <= `EVS_FC_SUP_DATA;
					end
					default: bus_req_out <= 1'b0;
				endcase
			end
		end
	end

	// ======================================================
	// Core control and read port
	// Hold drops together with the load pulse
	// Read data stand one cycle after the strobe, zero otherwise
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			core_hold_out   <= 1'b1;
			pc_load_out     <= 1'b0;
			pc_value_out    <= 32'h0000_0000;
			status_word_out <= `EVS_SR_RESET;
			reg_rdata_out   <= 32'h0000_0000;
		end else begin
			core_hold_out   <= (nxt_state != ST_RUN);
			pc_load_out     <= (state_ff == ST_LOAD) | (state_ff == ST_RUN && ex_return_in && ex_insn_done_in);
			pc_value_out    <= (state_ff == ST_RUN) ? ex_return_pc_in : pc_copy_ff;
			status_word_out <= nxt_sr;
			reg_rdata_out   <= 32'h0000_0000;
			if (reg_rd_in) begin
				case (reg_addr_in)
					`EVS_ADDR_BASE:    reg_rdata_out <= vbase_ff;
					`EVS_ADDR_STATUS:  reg_rdata_out <= {16'h0000, sr_ff};
					`EVS_ADDR_PC:      reg_rdata_out <= pc_copy_ff;
					`EVS_ADDR_SSP:     reg_rdata_out <= ssp_ff;
					`EVS_ADDR_LASTVEC: reg_rdata_out <= {23'h0, is_int_ff, vec_ff};
					default:           reg_rdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // evs_exception_vector_sequencer
`default_nettype wire

// *** evs_regs.vh ***
// Constants for the exception vector sequencer
// Behaviour
// - Base register marks a 1024-byte table of 256 vector entries.
// - Vectors 0-63 belong to the processor; the other 192 serve interrupts.
// - Each entry is one long word; the reset entry is two long words.
// - Vector fetches use supervisor data space; reset fetches use program space.
// - Only the reset entry is fixed; the base may be rewritten any time.
// - Reset fetches stack pointer from offset 000, program counter from 004.
// - Vectors 2-11: bus, address, illegal, divide, bounds, trap, privilege, trace, lines.
// - Vector 12 breakpoint, 13 reserved, 14 format error, 15 uninitialized interrupt.
// - Vector 24 spurious interrupt; 25-31 autovectors for levels 1-7.
// - Trap operands 0-15 select vectors 32-47.
// - Vectors 64-255 user defined; 16-23 and 48-63 never generated internally.
// - Offset is four times the 8-bit vector number, added to the base.
// - Interrupt numbers come from an acknowledge cycle to CPU space 15.
// - Entry first copies the status word, sets supervisor, clears both trace bits.
// - Only reset and interrupt entries update the interrupt priority mask.
// - Push a frame with saved status word and program counter on supervisor stack.
// - Load the fetched vector into the program counter and resume unless more pending.
// - Trap, conditional trap, bounds, breakpoint and divide instructions raise exceptions.
// - Illegal opcodes, odd fetch or operand addresses, privilege faults raise exceptions.
// - Trace mode traps after each instruction, optionally only on flow changes.
// - Opcodes 4848 to 484f are illegal and serve as software breakpoints.
// - The 1010 and 1111 opcode lines use their own vectors.
// - Saved status word and program counter are restored by the return instruction.
`ifndef EVS_REGS_VH
`define EVS_REGS_VH
// ==========================================================
// Register port map
`define EVS_ADDR_BASE     4'h0
`define EVS_ADDR_STATUS   4'h1
`define EVS_ADDR_PC       4'h2
`define EVS_ADDR_SSP      4'h3
`define EVS_ADDR_LASTVEC  4'h4
`define EVS_BASE_RESET    32'h0000_0000
// ==========================================================
// Status word fields
`define EVS_SR_TH   15
`define EVS_SR_TL   14
`define EVS_SR_S    13
`define EVS_SR_IPM_HI 10
`define EVS_SR_IPM_LO 8
`define EVS_SR_RESET  16'h2700
// ==========================================================
// Vector numbers
`define EVS_VEC_RST_SP   8'h00
`define EVS_VEC_RST_PC   8'h01
`define EVS_VEC_BUSERR   8'h02
`define EVS_VEC_ADDRERR  8'h03
`define EVS_VEC_ILLEGAL  8'h04
`define EVS_VEC_ZERODIV  8'h05
`define EVS_VEC_BOUNDS   8'h06
`define EVS_VEC_CONDITIONAL_TRAP_OP   8'h07
`define EVS_VEC_PRIV     8'h08
`define EVS_VEC_TRACE    8'h09
`define EVS_VEC_LINE_A   8'h0a
`define EVS_VEC_LINE_F   8'h0b
`define EVS_VEC_HWBKPT   8'h0c
`define EVS_VEC_FORMAT   8'h0e
`define EVS_VEC_UNINIT   8'h0f
`define EVS_VEC_SPUR     8'h18
`define EVS_VEC_AUTO0    8'h18
`define EVS_VEC_TRAP0    8'h20
`define EVS_VEC_USER0    8'h40
// ==========================================================
// Opcodes and bus spaces
`define EVS_OP_SWBKPT    13'h0909
`define EVS_FC_SUP_DATA  3'h5
`define EVS_FC_SUP_PROG  3'h6
`define EVS_FC_CPU       3'h7
`define EVS_CPU_SPACE_IACK 4'hf
`endif

// *** evs_sequencer_chk.sv ***
// Assertion checker for the exception vector sequencer ports
`timescale 1ns/10ps
`default_nettype none
module evs_sequencer_chk #(
	parameter AW = 32
) (
	input wire logic          clk_in,
	input wire logic          rst_n_in,
	input wire logic          reg_rd_in,
	input wire logic [31:0]   reg_rdata_out,
	input wire logic          bus_req_out,
	input wire logic          bus_wr_out,
	input wire logic [AW-1:0] bus_addr_out,
	input wire logic [2:0]    bus_fc_out,
	input wire logic          bus_ack_in,
	input wire logic          bus_err_in,
	input wire logic          bus_autovec_in,
	input wire logic [31:0]   bus_rdata_in,
	input wire logic          core_hold_out,
	input wire logic          pc_load_out,
	input wire logic [31:0]   pc_value_out,
	input wire logic [15:0]   status_word_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// ==========================================================
	// Bus cycle rules
	property p_rst_space;
		bus_req_out && bus_fc_out == 3'h6 |-> !bus_wr_out && (bus_addr_out == 0 || bus_addr_out == 4);
	endproperty
	a_rst_space: assert property (p_rst_space) else $error("reset fetch off its two entries");
	property p_req_hold;
		bus_req_out && !(bus_ack_in || bus_err_in || bus_autovec_in) |=>
			bus_req_out && $stable(bus_addr_out) && $stable(bus_fc_out) && $stable(bus_wr_out);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request changed before its answer");
	property p_push_order;
		bus_req_out && bus_wr_out && bus_ack_in |=> ##1 bus_req_out &&
			(bus_wr_out ? bus_addr_out == $past(bus_addr_out, 2) - 2 : bus_fc_out == 3'h5);
	endproperty
	a_push_order: assert property (p_push_order) else $error("frame push order broken");
	property p_fetch_align;
		bus_req_out && !bus_wr_out && bus_fc_out == 3'h5 |-> bus_addr_out[1:0] == 2'h0;
	endproperty
	a_fetch_align: assert property (p_fetch_align) else $error("vector fetch not long aligned");
	property p_iack;
		bus_req_out && bus_fc_out == 3'h7 |-> !bus_wr_out && status_word_out[13];
	endproperty
	a_iack: assert property (p_iack) else $error("acknowledge cycle malformed");
	property p_hold;
		bus_req_out |-> core_hold_out;
	endproperty
	a_hold: assert property (p_hold) else $error("bus cycle while core runs");
	// ==========================================================
	// Entry state, handler load and read port
	property p_super;
		bus_req_out && bus_wr_out |-> status_word_out[13] && !status_word_out[15] && !status_word_out[14];
	endproperty
	a_super: assert property (p_super) else $error("push without supervisor state");
	property p_load_value;
		bus_req_out && bus_ack_in && !bus_wr_out && (bus_fc_out == 3'h5 || (bus_fc_out == 3'h6 && bus_addr_out[2]))
			|=> ##1 pc_load_out && pc_value_out == $past(bus_rdata_in, 2);
	endproperty
	a_load_value: assert property (p_load_value) else $error("handler load wrong");
	property p_load_pulse;
		pc_load_out |=> !pc_load_out;
	endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("load longer than a pulse");
	property p_rd_idle;
		!reg_rd_in |=> reg_rdata_out == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule // evs_sequencer_chk
bind evs_exception_vector_sequencer evs_sequencer_chk #(.AW(AW)) u_chk (.clk_in, .rst_n_in, .reg_rd_in,
	.reg_rdata_out, .bus_req_out, .bus_wr_out, .bus_addr_out, .bus_fc_out, .bus_ack_in, .bus_err_in,
	.bus_autovec_in, .bus_rdata_in, .core_hold_out, .pc_load_out, .pc_value_out, .status_word_out);
`default_nettype wire

// *** evs_testbench.sv ***
// Self-checking testbench for the exception vector sequencer
`timescale 1ns/10ps
`default_nettype none
`include "evs_regs.vh"
module testbench;
	// ==========================================================
	// Signals
	logic        clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, rd_d = 1'b0;
	logic [3:0]  reg_addr_in = 4'h0, ex_trap_num_in = 4'h0;
	logic [31:0] reg_wdata_in = 32'h0, ex_return_pc_in = 32'h0, core_pc_in = 32'h0, base = 32'h0;
	logic [13:0] cz = 14'h0;
	logic [15:0] ex_opcode_in = 16'h0, ex_return_sr_in = 16'h0;
	logic [2:0]  irq_level_in = 3'h0, dly = 3'h0;
	logic [1:0]  iack_mode = 2'h0;
	logic [7:0]  iack_vec = 8'h0;
	wire         bus_req_out, bus_wr_out, bus_ack_in, bus_err_in, bus_autovec_in, core_hold_out, pc_load_out;
	wire  [31:0] reg_rdata_out, bus_addr_out, bus_wdata_out, bus_rdata_in, pc_value_out;
	wire  [2:0]  bus_fc_out;
	wire  [15:0] status_word_out;
	logic [31:0] pq[$], rq[$], wq[$];
	int          errors = 0, n_compared = 0, seed = 38205, k;
	// Cause table: flags, opcode, vector
	logic [37:0] tbl [11] = '{{14'h0080, 16'h0, 8'h02}, {14'h0040, 16'h0, 8'h03}, {14'h1000, 16'h4848, 8'h04},
		{14'h0008, 16'h0, 8'h05}, {14'h0004, 16'h0, 8'h06}, {14'h0002, 16'h0, 8'h07}, {14'h0020, 16'h0, 8'h08},
		{14'h1000, 16'ha123, 8'h0a}, {14'h1000, 16'hf456, 8'h0b}, {14'h0100, 16'h0, 8'h0c}, {14'h0010, 16'h0, 8'h0e}};
	always #5 clk_in = ~clk_in;
	evs_exception_vector_sequencer dut_u (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
		.reg_rdata_out, .ex_trap_in(cz[0]), .ex_trap_num_in, .ex_cond_trap_in(cz[1]), .ex_bounds_in(cz[2]),
		.ex_divzero_in(cz[3]), .ex_format_in(cz[4]), .ex_priv_in(cz[5]), .ex_odd_addr_in(cz[6]),
		.ex_bus_err_in(cz[7]), .ex_hw_breakpoint_op_in(cz[8]), .ex_insn_done_in(cz[9]), .ex_flow_change_in(cz[10]),
		.ex_trace_flow_only_in(cz[11]), .ex_opcode_valid_in(cz[12]), .ex_opcode_in, .ex_return_in(cz[13]),
		.ex_return_sr_in, .ex_return_pc_in, .core_pc_in, .irq_level_in, .bus_req_out, .bus_wr_out, .bus_addr_out,
		.bus_fc_out, .bus_wdata_out, .bus_ack_in, .bus_err_in, .bus_autovec_in, .bus_rdata_in, .core_hold_out,
		.pc_load_out, .pc_value_out, .status_word_out);
	evs_bus_partner mem_u (.clk_in, .rst_n_in, .bus_req_in(bus_req_out), .bus_addr_in(bus_addr_out),
		.bus_fc_in(bus_fc_out), .dly_in(dly), .iack_mode_in(iack_mode), .iack_vec_in(iack_vec),
		.ack_out(bus_ack_in), .err_out(bus_err_in), .autovec_out(bus_autovec_in), .rdata_out(bus_rdata_in));
	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("compared=%0d errors=%0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic reg_op(input logic [3:0] a, input logic [31:0] d, input logic rd);
		@(posedge clk_in);
		if (rd) rq.push_back(d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_rd_in <= rd;
		reg_wr_in <= !rd;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		reg_wr_in <= 1'b0;
	endtask
	task automatic wait_load;
		for (k = 0; k < 300 && pc_load_out !== 1'b1; k++) begin
			@(posedge clk_in);
			if (bus_req_out === 1'b1 && bus_fc_out === `EVS_FC_CPU) irq_level_in <= 3'h0;
		end
		if (k == 300) begin
			errors++;
			finish_test();
		end
		repeat (3) @(posedge clk_in);
	endtask
	// One exception: drive cause, note handler word, check status and vector number
	task automatic run_case(input logic [13:0] m, input logic [15:0] op, input logic [3:0] tn,
		input logic [7:0] v, input logic [2:0] lvl, input logic intr);
		logic [15:0] sr;
		logic [31:0] pc;
		@(posedge clk_in);
		sr = (status_word_out & 16'h3fff) | 16'h2000;
		if (intr) sr[10:8] = lvl;
		cz <= m;
		ex_opcode_in <= op;
		ex_trap_num_in <= tn;
		irq_level_in <= lvl;
		dly <= 3'($random(seed));
		pc = $random(seed);
		core_pc_in <= pc;
		wq.push_back(pc);
		wq.push_back({16'h0, status_word_out});
		pq.push_back({~base[15:0] - 16'(4 * v), base[15:0] + 16'(4 * v)});
		@(posedge clk_in);
		cz <= 14'h0;
		wait_load();
		check({16'h0, sr}, {16'h0, status_word_out});
		reg_op(`EVS_ADDR_LASTVEC, {23'h0, intr, v}, 1'b1);
	endtask
	task automatic ret(input logic [15:0] sr);
		@(posedge clk_in);
		ex_return_sr_in <= sr;
		ex_return_pc_in <= base ^ 32'h0000_1234;
		pq.push_back(base ^ 32'h0000_1234);
		cz <= 14'h2200;
		@(posedge clk_in);
		cz <= 14'h0;
		wait_load();
		check({16'h0, sr}, {16'h0, status_word_out});
	endtask
	// ==========================================================
	// Result watcher: loads and read data against the oldest notes
	always @(posedge clk_in) begin
		rd_d <= reg_rd_in;
		if (pc_load_out === 1'b1) check(pq.size() ? pq.pop_front() : 32'hx, pc_value_out);
		if (rd_d === 1'b1) check(rq.size() ? rq.pop_front() : 32'hx, reg_rdata_out);
		if (bus_req_out === 1'b1 && bus_wr_out === 1'b1 && bus_ack_in === 1'b1)
			check(wq.size() ? wq.pop_front() : 32'hx, bus_wdata_out);
	end
	// ==========================================================
	// Main sequence
	initial begin
		pq.push_back(32'hfffb_0004);
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		wait_load();
		reg_op(`EVS_ADDR_BASE, 32'h0, 1'b1);
		reg_op(4'hf, 32'h0, 1'b1);
		base = $random(seed) & 32'h00ff_fffc;
		reg_op(`EVS_ADDR_BASE, base, 1'b0);
		reg_op(`EVS_ADDR_BASE, base, 1'b1);
		reg_op(`EVS_ADDR_SSP, 32'h0000_8000, 1'b0);
		reg_op(`EVS_ADDR_SSP, 32'h0000_8000, 1'b1);
		for (int i = 0; i < 11; i++)
			run_case(tbl[i][37:24], tbl[i][23:8], 4'h0, tbl[i][7:0], 3'h0, 1'b0);
		reg_op(`EVS_ADDR_STATUS, 32'h0000_a700, 1'b0);
		reg_op(`EVS_ADDR_STATUS, 32'h0000_a700, 1'b1);
		run_case(14'h0e00, 16'h0, 4'h0, 8'h09, 3'h0, 1'b0);
		base = $random(seed) & 32'h00ff_fffc;
		reg_op(`EVS_ADDR_BASE, base, 1'b0);
		for (int i = 0; i < 16; i++) run_case(14'h0001, 16'h0, 4'(i), 8'(8'h20 + i), 3'h0, 1'b0);
		ret(16'h2000);
		iack_mode = 2'h0;
		iack_vec = 8'h47;
		run_case(14'h0, 16'h0, 4'h0, 8'h47, 3'h5, 1'b1);
		ret(16'h2000);
		iack_mode = 2'h1;
		run_case(14'h0, 16'h0, 4'h0, 8'h1b, 3'h3, 1'b1);
		ret(16'h2000);
		iack_mode = 2'h2;
		run_case(14'h0, 16'h0, 4'h0, 8'h18, 3'h7, 1'b1);
		iack_mode = 2'h1;
		run_case(14'h0, 16'h0, 4'h0, 8'h1f, 3'h7, 1'b1);
		finish_test();
	end
endmodule // testbench
`default_nettype wire
